// *** hdl/iofm_params.svh ***
// Constants of the I/O function mapping block: register offsets, field positions and timing.
`ifndef IOFM_PARAMS_SVH
`define IOFM_PARAMS_SVH
`define IOFM_CLK_HZ 40000000
`define IOFM_DELAY_UNIT_US 1000
`define IOFM_CYC_PER_MS ((`IOFM_CLK_HZ / 1000000) * `IOFM_DELAY_UNIT_US)
`define IOFM_DEF_DELAY_MS 8'h4B
`define IOFM_OFS_CON0 12'h000
`define IOFM_OFS_OUT0 12'h010
`define IOFM_OFS_INP0 12'h020
`define IOFM_OFS_BOOL 12'h030
`define IOFM_OFS_STAT 12'h034
`define IOFM_OFS_LIM 12'h038
`define IOFM_CON_EN 0
`define IOFM_CON_INV 1
`define IOFM_CON_DIR_LO 2
`define IOFM_CON_SRC_LO 4
`define IOFM_CON_DLY_LO 16
`define IOFM_PIN_EN 0
`define IOFM_PIN_INV 1
`define IOFM_PIN_RISE 2
`define IOFM_PIN_FALL 3
`define IOFM_PIN_SEL_LO 4
`define IOFM_DIR_NONE 2'h0
`define IOFM_DIR_CHG 2'h1
`define IOFM_DIR_DIS 2'h2
`define IOFM_SRC_PRE 5'h00
`define IOFM_SRC_MAIN 5'h01
`define IOFM_SRC_STACK 5'h02
`define IOFM_SRC_CHG_EN 5'h03
`define IOFM_SRC_DIS_EN 5'h04
`define IOFM_SRC_SAFE 5'h05
`define IOFM_SRC_TRIG 5'h06
`define IOFM_SRC_CLR 5'h07
`define IOFM_SRC_CONN 5'h08
`define IOFM_SRC_GEN 5'h10
`endif

// *** hdl/iofm_pkg.sv ***
// Types of the I/O function mapping block.
package iofm_pkg;
  typedef struct packed {
    logic [7:0] delay_ms;
    logic [4:0] src;
    logic [1:0] dir;
    logic inv;
    logic en;
  } iofm_con_s;
  typedef struct packed {
    logic [4:0] sel;
    logic fall;
    logic rise;
    logic inv;
    logic en;
  } iofm_pin_s;
  typedef enum {IOFM_CLOSED, IOFM_WAIT, IOFM_OPEN} iofm_open_e;
endpackage : iofm_pkg

// *** hdl/iofm_top.sv ***
// I/O function mapping: contactor drivers, digital outputs, digital inputs and fault pilot, APB slave.
`timescale 1ns/1ps
`include "iofm_params.svh"

module iofm_top #(
  parameter int NUM_CON = 4,
  parameter int NUM_OUT = 4,
  parameter int NUM_INP = 4,
  parameter int CYC_PER_MS = `IOFM_CYC_PER_MS
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sequencer and safety state.
  input wire logic PRECHARGE_SW,
  input wire logic MAIN_SW,
  input wire logic STACK_SW,
  input wire logic FAULT,
  input wire logic TRIG_TRIPPED,
  input wire logic CPU_ALIVE,
  input wire logic CURRENT_CHARGING,
  // Pins.
  input wire logic [3:0] INPUT_PIN,
  output logic [3:0] COIL,
  output logic [3:0] OUTPUT_SW,
  output logic FAULT_PILOT,
  // Functions fed by the inputs.
  output logic CLEAR_FAULTS,
  output logic CONNECT_REQ
);
  // Elaboration check: the map holds exactly four of each.
  if (NUM_CON != 4 || NUM_OUT != 4 || NUM_INP != 4 || CYC_PER_MS < 1)
    $error("iofm_top: unsupported parameter values");

  iofm_pkg::iofm_con_s con [NUM_CON];
  iofm_pkg::iofm_pin_s outp [NUM_OUT];
  iofm_pkg::iofm_pin_s inp [NUM_INP];
  iofm_pkg::iofm_open_e ost [NUM_CON];
  logic [15:0] gen_bool;
  logic [15:0] chg_limit;
  logic [15:0] dis_limit;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_d;
  logic [31:0] wait_cnt [NUM_CON];
  logic [31:0] next_rdata;
  logic [31:0] funcs;

  // Function bus: one bit per selectable Boolean.
  function automatic logic pick(input logic [31:0] f, input logic [4:0] s);
    pick = f[s];
  endfunction : pick

  // Reduction of the current limits to enable functions and the function vector.
  wire chg_en = |chg_limit;
  wire dis_en = |dis_limit;
  wire safe = ~FAULT;
  always_comb
  begin
    funcs = 32'h0;
    funcs[`IOFM_SRC_PRE] = PRECHARGE_SW;
    funcs[`IOFM_SRC_MAIN] = MAIN_SW;
    funcs[`IOFM_SRC_STACK] = STACK_SW;
    funcs[`IOFM_SRC_CHG_EN] = chg_en;
    funcs[`IOFM_SRC_DIS_EN] = dis_en;
    funcs[`IOFM_SRC_SAFE] = safe;
    funcs[`IOFM_SRC_TRIG] = TRIG_TRIPPED;
    funcs[`IOFM_SRC_CLR] = CLEAR_FAULTS;
    funcs[`IOFM_SRC_CONN] = CONNECT_REQ;
    funcs[31:16] = gen_bool;
  end

  // Fault pilot trips on a fault or when the processor stops signalling.
  wire pilot = FAULT | ~CPU_ALIVE;

  // APB decode.
  wire wr = PSEL & PENABLE & PWRITE;
  wire [3:0] widx = PADDR[5:2];
  wire mapped = PADDR[1:0] == 2'h0 && PADDR <= `IOFM_OFS_LIM;
  always_comb
  begin
    next_rdata = 32'h0;
    if (PADDR < `IOFM_OFS_OUT0)
      next_rdata = {8'h0, con[widx[1:0]].delay_ms, 7'h0, con[widx[1:0]].src, con[widx[1:0]].dir,
        con[widx[1:0]].inv, con[widx[1:0]].en};
    else if (PADDR < `IOFM_OFS_INP0)
      next_rdata = 32'(outp[widx[1:0]]);
    else if (PADDR < `IOFM_OFS_BOOL)
      next_rdata = 32'(inp[widx[1:0]]);
    else if (PADDR == `IOFM_OFS_BOOL)
      next_rdata = {16'h0, gen_bool};
    else if (PADDR == `IOFM_OFS_STAT)
      next_rdata = {20'h0, FAULT_PILOT, CONNECT_REQ, CLEAR_FAULTS, OUTPUT_SW, COIL, 1'b0} >> 1;
    else if (PADDR == `IOFM_OFS_LIM)
      next_rdata = {dis_limit, chg_limit};
  end

  // APB answer: zero wait states; unmapped addresses give an error.
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end
    else
    begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~mapped;
      PRDATA <= (PSEL & ~PENABLE & ~PWRITE & mapped) ? next_rdata : 32'h0;
    end
  end

  // Configuration writes; writes land in the access cycle.
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < NUM_CON; i++)
        con[i] <= '{delay_ms: `IOFM_DEF_DELAY_MS, src: 5'h0, dir: 2'h0, inv: 1'b0, en: 1'b0};
      for (int i = 0; i < NUM_OUT; i++)
        outp[i] <= '0;
      for (int i = 0; i < NUM_INP; i++)
        inp[i] <= '0;
      chg_limit <= 16'h0;
      dis_limit <= 16'h0;
    end
    else if (wr && PREADY)
    begin
      if (PADDR < `IOFM_OFS_OUT0)
        con[widx[1:0]] <= '{delay_ms: PWDATA[`IOFM_CON_DLY_LO +: 8], src: PWDATA[`IOFM_CON_SRC_LO +: 5],
          dir: PWDATA[`IOFM_CON_DIR_LO +: 2], inv: PWDATA[`IOFM_CON_INV], en: PWDATA[`IOFM_CON_EN]};
      else if (PADDR < `IOFM_OFS_INP0)
        outp[widx[1:0]] <= iofm_pkg::iofm_pin_s'(PWDATA[8:0]);
      else if (PADDR < `IOFM_OFS_BOOL)
        inp[widx[1:0]] <= iofm_pkg::iofm_pin_s'(PWDATA[8:0]);
      else if (PADDR == `IOFM_OFS_LIM)
      begin
        chg_limit <= PWDATA[15:0];
        dis_limit <= PWDATA[31:16];
      end
    end
  end

  // Input pin synchroniser and previous-value register for edge detection.
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_d <= 4'h0;
    end
    else
    begin
      pin_s1 <= INPUT_PIN;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // Input write strobes: level mode copies every cycle, edge modes copy on the chosen edges.
  logic [3:0] in_val;
  logic [3:0] in_wr;
  always_comb
  begin
    for (int i = 0; i < NUM_INP; i++)
    begin
      in_val[i] = pin_s2[i] ^ inp[i].inv;
      in_wr[i] = inp[i].en & (
        (~inp[i].rise & ~inp[i].fall) |
        (inp[i].rise & pin_s2[i] & ~pin_d[i]) |
        (inp[i].fall & ~pin_s2[i] & pin_d[i]));
    end
  end

  // Destination registers; a later input index wins a shared destination.
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      gen_bool <= 16'h0;
      CLEAR_FAULTS <= 1'b0;
      CONNECT_REQ <= 1'b0;
    end
    else
    begin
      if (wr && PREADY && PADDR == `IOFM_OFS_BOOL)
        gen_bool <= PWDATA[15:0];
      for (int i = 0; i < NUM_INP; i++)
        if (in_wr[i])
        begin
          if (inp[i].sel == `IOFM_SRC_CLR)
            CLEAR_FAULTS <= in_val[i];
          else if (inp[i].sel == `IOFM_SRC_CONN)
            CONNECT_REQ <= in_val[i];
          else if (inp[i].sel[4])
            gen_bool[inp[i].sel[3:0]] <= in_val[i];
        end
    end
  end

  // Contactor command, opening order and delay per contactor.
  logic [3:0] con_cmd;
  logic [3:0] con_opposed;
  always_comb
  begin
    for (int i = 0; i < NUM_CON; i++)
    begin
      con_cmd[i] = con[i].en & (pick(funcs, con[i].src) ^ con[i].inv);
      con_opposed[i] = (con[i].dir == `IOFM_DIR_CHG && !CURRENT_CHARGING) ||
        (con[i].dir == `IOFM_DIR_DIS && CURRENT_CHARGING);
    end
  end
  // Every contactor that is not opposed and whose command has dropped must already be open.
  wire aligned_open_all = &(~COIL | con_opposed | con_cmd);

  // Per-contactor state: closed, waiting out its delay, or open.
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < NUM_CON; i++)
      begin
        ost[i] <= iofm_pkg::IOFM_OPEN;
        wait_cnt[i] <= 32'h0;
      end
      COIL <= 4'h0;
    end
    else
      for (int i = 0; i < NUM_CON; i++)
        case (ost[i])
          iofm_pkg::IOFM_OPEN:
            if (con_cmd[i] && !pilot)
            begin
              ost[i] <= iofm_pkg::IOFM_CLOSED;
              COIL[i] <= 1'b1;
            end
          iofm_pkg::IOFM_CLOSED:
            if (pilot || !con_cmd[i])
            begin
              if (pilot || !con_opposed[i])
              begin
                ost[i] <= iofm_pkg::IOFM_OPEN;
                COIL[i] <= 1'b0;
              end
              else
              begin
                ost[i] <= iofm_pkg::IOFM_WAIT;
                wait_cnt[i] <= 32'(con[i].delay_ms) * 32'(CYC_PER_MS);
              end
            end
          iofm_pkg::IOFM_WAIT:
            if (pilot || (aligned_open_all && wait_cnt[i] <= 32'h1))
            begin
              ost[i] <= iofm_pkg::IOFM_OPEN;
              COIL[i] <= 1'b0;
            end
            else if (con_cmd[i])
              ost[i] <= iofm_pkg::IOFM_CLOSED;
            else if (wait_cnt[i] > 32'h1)
              wait_cnt[i] <= wait_cnt[i] - 32'h1;
          default:
            ost[i] <= iofm_pkg::IOFM_OPEN;
        endcase
  end

  // Output switches and fault pilot.
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      OUTPUT_SW <= 4'h0;
      FAULT_PILOT <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_OUT; i++)
        OUTPUT_SW[i] <= outp[i].en & ~(pick(funcs, outp[i].sel) ^ outp[i].inv);
      FAULT_PILOT <= pilot;
    end
  end

  // Assertions.
  property p_coil_disabled;
    @(posedge MCLK) disable iff (!RESET_N) !con[0].en |=> !COIL[0] || $past(ost[0]) != iofm_pkg::IOFM_OPEN;
  endproperty
  a_coil_disabled: assert property (p_coil_disabled) else $error("coil energized while disabled");
  property p_pilot_opens;
    @(posedge MCLK) disable iff (!RESET_N) pilot ##1 pilot |=> COIL == 4'h0;
  endproperty
  a_pilot_opens: assert property (p_pilot_opens) else $error("pilot did not open coils");
  property p_out_disabled;
    @(posedge MCLK) disable iff (!RESET_N) !outp[0].en |=> !OUTPUT_SW[0];
  endproperty
  a_out_disabled: assert property (p_out_disabled) else $error("output closed while disabled");
  property p_pilot_follow;
    @(posedge MCLK) disable iff (!RESET_N) FAULT |=> FAULT_PILOT;
  endproperty
  a_pilot_follow: assert property (p_pilot_follow) else $error("fault pilot missed fault");
  property p_apb_ready;
    @(posedge MCLK) disable iff (!RESET_N) PSEL && !PENABLE |=> PREADY;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
  property p_level_copy;
    @(posedge MCLK) disable iff (!RESET_N)
      inp[1].en && !inp[1].rise && !inp[1].fall && inp[1].sel == `IOFM_SRC_CONN && in_wr == 4'h2
      |=> CONNECT_REQ == $past(in_val[1]);
  endproperty
  a_level_copy: assert property (p_level_copy) else $error("level copy missed");
  property p_rise_only;
    @(posedge MCLK) disable iff (!RESET_N)
      inp[0].en && inp[0].rise && !inp[0].fall && !(pin_s2[0] && !pin_d[0]) |-> !in_wr[0];
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("write without rising edge");
  property p_fall_only;
    @(posedge MCLK) disable iff (!RESET_N)
      inp[2].en && inp[2].fall && !inp[2].rise && !(!pin_s2[2] && pin_d[2]) |-> !in_wr[2];
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("write without falling edge");
  // Opposed contactor whose command drops while the pilot is quiet.
  sequence s_opposed_drop;
    ost[1] == iofm_pkg::IOFM_CLOSED && !con_cmd[1] && con_opposed[1] && !pilot;
  endsequence
  // The coil stays energized while the opposed contactor waits.
  sequence s_opposed_waiting;
    COIL[1] && ost[1] == iofm_pkg::IOFM_WAIT;
  endsequence
  property p_opposed_holds;
    @(posedge MCLK) disable iff (!RESET_N) s_opposed_drop |=> s_opposed_waiting;
  endproperty
  a_opposed_holds: assert property (p_opposed_holds) else $error("opposed contactor opened early");
  property p_pilot_blocks;
    @(posedge MCLK) disable iff (!RESET_N) pilot && ost[0] == iofm_pkg::IOFM_OPEN |=> !COIL[0];
  endproperty
  a_pilot_blocks: assert property (p_pilot_blocks) else $error("contactor closed under pilot");
  property p_inp_disabled;
    @(posedge MCLK) disable iff (!RESET_N) !inp[0].en |-> !in_wr[0];
  endproperty
  a_inp_disabled: assert property (p_inp_disabled) else $error("disabled input wrote");
  property p_bad_addr;
    @(posedge MCLK) disable iff (!RESET_N) PSEL && !PENABLE && !mapped |=> PSLVERR;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("no error for unmapped address");
endmodule : iofm_top

// *** verif/iofm_far_end.sv ***
// Model of the external switches that drive the digital input pins.
`timescale 1ns/1ps
module iofm_far_end (
  // Clock.
  input wire logic mclk,
  // Pins towards the block.
  output logic [3:0] pins
);
  // Switch contacts start open, so every pin is deasserted.
  initial pins = 4'h0;

  // Changes one pin just after a rising edge, as a real switch settles between edges.
  task automatic set_pin(input int idx, input logic val);
    @(posedge mclk);
    pins[idx] <= val;
  endtask : set_pin
endmodule : iofm_far_end

// *** verif/testbench.sv ***
// Self-checking testbench of the I/O function mapping block.
`timescale 1ns/1ps
`include "iofm_params.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench;
  localparam int CPM = 4;
  logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr;
  logic pre_sw = 0, main_sw = 0, stack_sw = 0, fault = 0, trig = 0, cpu_alive = 1, charging = 0;
  logic [3:0] pins, coil, out_sw;
  logic pilot, clr, conn;
  int err_total = 0, total_checks = 0;

  // Clock of 25 ns period.
  initial forever #12.5 mclk = ~mclk;

  // Far-side switch model feeding the input pins.
  iofm_far_end i_far (.mclk(mclk), .pins(pins));

  // Block under test, with a short millisecond count.
  iofm_top #(.CYC_PER_MS(CPM)) i_dut (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PRECHARGE_SW(pre_sw), .MAIN_SW(main_sw), .STACK_SW(stack_sw),
    .FAULT(fault), .TRIG_TRIPPED(trig), .CPU_ALIVE(cpu_alive), .CURRENT_CHARGING(charging),
    .INPUT_PIN(pins), .COIL(coil), .OUTPUT_SW(out_sw), .FAULT_PILOT(pilot),
    .CLEAR_FAULTS(clr), .CONNECT_REQ(conn));

  // Builds a contactor configuration word.
  function automatic logic [31:0] cw(logic en, logic inv, logic [1:0] dir, logic [4:0] src, logic [7:0] dly);
    return {8'h00, dly, 7'h00, src, dir, inv, en};
  endfunction : cw

  // Builds an output or input pin configuration word.
  function automatic logic [31:0] pw(logic en, logic inv, logic rise, logic fall, logic [4:0] sel);
    return {23'h0, sel, fall, rise, inv, en};
  endfunction : pw

  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      results();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // Reset state, default delay and an unmapped address.
  task automatic sc_reset;
    `CHK("coil", 4'h0, coil)
    apb(0, `IOFM_OFS_CON0 + 12'h004, 32'h0);
    `CHK("dly", {8'h00, `IOFM_DEF_DELAY_MS, 16'h0000}, rdata)
    apb(0, 12'h03C, 32'h0);
    `CHK("slverr", 1'b1, rerr)
  endtask : sc_reset

  // Enable, inversion, source, ordered opening and opposed delay.
  task automatic sc_contactor;
    apb(1, 12'h000, cw(1, 0, `IOFM_DIR_NONE, `IOFM_SRC_MAIN, 8'h00));
    apb(1, 12'h004, cw(1, 0, `IOFM_DIR_CHG, `IOFM_SRC_MAIN, 8'h02));
    apb(1, 12'h008, cw(0, 0, `IOFM_DIR_NONE, `IOFM_SRC_MAIN, 8'h00));
    apb(1, 12'h00C, cw(1, 1, `IOFM_DIR_DIS, `IOFM_SRC_STACK, 8'h00));
    main_sw <= 1;
    stack_sw <= 1;
    repeat (3) @(posedge mclk);
    `CHK("coil on", 4'b0011, coil)
    main_sw <= 0;
    repeat (3) @(posedge mclk);
    `CHK("coil aligned open", 4'b0010, coil)
    repeat (6) @(posedge mclk);
    `CHK("coil opposed waits", 4'b0010, coil)
    repeat (4) @(posedge mclk);
    `CHK("coil opposed open", 4'b0000, coil)
    stack_sw <= 0;
    repeat (3) @(posedge mclk);
    `CHK("coil inverted", 4'b1000, coil)
  endtask : sc_contactor

  // A fault opens everything at once; processor failure raises the fault pilot.
  task automatic sc_pilot;
    apb(1, 12'h004, cw(1, 0, `IOFM_DIR_CHG, `IOFM_SRC_MAIN, 8'hC8));
    main_sw <= 1;
    repeat (3) @(posedge mclk);
    fault <= 1;
    repeat (3) @(posedge mclk);
    `CHK("pilot", 1'b1, pilot)
    `CHK("coil fault", 4'b0000, coil)
    fault <= 0;
    cpu_alive <= 0;
    repeat (3) @(posedge mclk);
    `CHK("pilot cpu", 1'b1, pilot)
    cpu_alive <= 1;
    main_sw <= 0;
  endtask : sc_pilot

  // Output enable, polarity and the common functions.
  task automatic sc_outputs;
    apb(1, `IOFM_OFS_LIM, 32'h0000_0005);
    apb(1, 12'h010, pw(1, 1, 0, 0, `IOFM_SRC_SAFE));
    apb(1, 12'h014, pw(1, 1, 0, 0, `IOFM_SRC_CHG_EN));
    apb(1, 12'h018, pw(0, 1, 0, 0, `IOFM_SRC_TRIG));
    apb(1, 12'h01C, pw(1, 0, 0, 0, `IOFM_SRC_DIS_EN));
    trig <= 1;
    repeat (3) @(posedge mclk);
    `CHK("out", 4'b1011, out_sw)
    apb(1, 12'h018, pw(1, 1, 0, 0, `IOFM_SRC_TRIG));
    fault <= 1;
    repeat (3) @(posedge mclk);
    `CHK("out fault", 4'b1110, out_sw)
    fault <= 0;
  endtask : sc_outputs

  // Continuous, inverted, rising and falling input copies.
  task automatic sc_inputs;
    apb(1, 12'h020, pw(1, 0, 1, 0, `IOFM_SRC_CLR));
    apb(1, 12'h024, pw(1, 1, 0, 0, `IOFM_SRC_CONN));
    apb(1, 12'h028, pw(1, 0, 0, 1, `IOFM_SRC_CLR));
    repeat (5) @(posedge mclk);
    `CHK("conn inv", 1'b1, conn)
    i_far.set_pin(1, 1);
    repeat (5) @(posedge mclk);
    `CHK("conn cont", 1'b0, conn)
    i_far.set_pin(0, 1);
    repeat (5) @(posedge mclk);
    `CHK("clr rise", 1'b1, clr)
    i_far.set_pin(2, 1);
    i_far.set_pin(0, 0);
    repeat (5) @(posedge mclk);
    `CHK("clr hold", 1'b1, clr)
    i_far.set_pin(2, 0);
    repeat (5) @(posedge mclk);
    `CHK("clr fall", 1'b0, clr)
    apb(1, 12'h02C, pw(1, 0, 1, 1, `IOFM_SRC_GEN));
    i_far.set_pin(3, 1);
    repeat (5) @(posedge mclk);
    apb(0, `IOFM_OFS_BOOL, 32'h0);
    `CHK("gen both rise", 32'h0000_0001, rdata)
    i_far.set_pin(3, 0);
    repeat (5) @(posedge mclk);
    apb(0, `IOFM_OFS_BOOL, 32'h0);
    `CHK("gen both fall", 32'h0000_0000, rdata)
  endtask : sc_inputs

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge mclk);
    reset_n <= 1;
    sc_reset();
    sc_contactor();
    sc_pilot();
    sc_outputs();
    sc_inputs();
    results();
  end
endmodule : testbench
